// ==== hw/tdm_clk_host.sv ====
// Purpose: Host controller that programs a board's clock mode and tracks
//          its clock error reports over a byte link.
// Assumes: The link runs on LINK_CLK; the user side runs on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_clk_defs.svh"

module tdm_clk_sync (
    input  wire logic clk,
    input  wire logic d,
    output var  logic q
);
    logic [2:0] s_q;
    // A change counts only once the second and third stages agree.
    always_ff @(posedge clk) begin
        s_q <= {s_q[1:0], d};
        if (s_q[1] == s_q[2]) begin
            q <= s_q[2];
        end
    end
endmodule : tdm_clk_sync

module tdm_clk_host
    import tdm_clk_pkg::*;
(
    // Core clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    // Set-clock request
    input  wire logic       CMD_VALID,
    output logic            CMD_READY,
    input  wire clk_cmd_s   CMD,
    output logic            CMD_REJECT,
    // Connection request check
    input  wire logic       CONN_VALID,
    input  wire logic [15:0] CONN_SLOT,
    output logic            CONN_GRANT,
    output logic            CONN_REJECT,
    // Status
    output logic            CLOCK_SET,
    output var clk_cmd_s    CUR_CMD,
    output logic [7:0]      ERR_VECTOR,
    output logic            ERR_VALID,
    output logic            RESEND_NEEDED,
    // Link to the board
    input  wire logic       LINK_CLK,
    output logic            LINK_TX_VALID,
    output logic [7:0]      LINK_TX_DATA,
    input  wire logic       LINK_TX_READY,
    input  wire logic       LINK_RX_VALID,
    input  wire logic [7:0] LINK_RX_DATA
);
    // ---------------- core domain ----------------
    clk_cmd_s   hold_q;
    logic       busy_q, req_tgl_q, ack_seen_q, err_seen_q, err_ack_tgl_q;
    logic       ack_sync, err_sync;
    logic       set_q, rej_q, grant_q, crej_q, errv_q, resend_q;
    clk_cmd_s   cur_q;
    logic [7:0] errvec_q;
    logic [7:0] err_hold_q;
    // Toggles owned by the link domain, declared here for the synchronisers.
    logic       ack_tgl_q, err_tgl_q;

    function automatic logic cmd_ok(input clk_cmd_s c);
        logic master;
        master = (c.mode >= `MODE_PRI_A) && (c.mode <= `MODE_SEC_B);
        cmd_ok = 1'b1;
        if (c.mode > `MODE_SEC_B) cmd_ok = 1'b0;
        if (c.mode == `MODE_SLAVE &&
            !(c.submode == `SUB_SLV_A || c.submode == `SUB_SLV_B ||
              c.submode == `SUB_SLV_A_FB || c.submode == `SUB_SLV_B_FB))
            cmd_ok = 1'b0;
        if (c.mode == `MODE_SLAVE && c.arg_a > `ARG_A_MAX)
            cmd_ok = 1'b0;
        if (master && c.arg_a != 4'h0) cmd_ok = 1'b0;
        if (master && c.submode > `SUB_MST_MAX) cmd_ok = 1'b0;
        if ((c.mode == `MODE_SEC_A || c.mode == `MODE_SEC_B) &&
            c.submode > `SUB_SEC_MAX) cmd_ok = 1'b0;
        if (master && (c.submode == `SUB_NETREF_ONE ||
            c.submode == `SUB_NETREF_TWO) && c.arg_bb != `NETREF_8K)
            cmd_ok = 1'b0;
    endfunction : cmd_ok

    // Which error bit marks loss of the primary clock for the current mode.
    function automatic logic primary_lost(input clk_cmd_s c,
                                          input logic [7:0] e);
        primary_lost = 1'b0;
        if (c.mode == `MODE_SLAVE && c.submode == `SUB_SLV_A_FB)
            primary_lost = e[`ERR_BUS_A];
        if (c.mode == `MODE_SLAVE && c.submode == `SUB_SLV_B_FB)
            primary_lost = e[`ERR_BUS_B];
        if (c.mode == `MODE_SEC_A) primary_lost = e[`ERR_BUS_B];
        if (c.mode == `MODE_SEC_B) primary_lost = e[`ERR_BUS_A];
    endfunction : primary_lost

    wire       take_cmd  = CMD_VALID && !busy_q;
    wire       cmd_good  = cmd_ok(CMD);
    wire       ack_evt   = ack_sync != ack_seen_q;
    wire       err_evt   = err_sync != err_seen_q;
    // Legacy bits never reach software.
    wire [7:0] err_clean = err_hold_q & `ERR_KEEP_MASK;
    wire       conn_ok   = set_q && CONN_SLOT[15:8] <= `STREAM_MAX &&
                           CONN_SLOT[7:0] <= `SLOT_MAX;
    wire       lost      = err_evt && primary_lost(cur_q, err_clean);

    assign CMD_READY     = !busy_q;
    assign CMD_REJECT    = rej_q;
    assign CONN_GRANT    = grant_q;
    assign CONN_REJECT   = crej_q;
    assign CLOCK_SET     = set_q;
    assign CUR_CMD       = cur_q;
    assign ERR_VECTOR    = errvec_q;
    assign ERR_VALID     = errv_q;
    assign RESEND_NEEDED = resend_q;

    tdm_clk_sync u_ack_sync (.clk(CORE_CLK), .d(ack_tgl_q), .q(ack_sync));
    tdm_clk_sync u_err_sync (.clk(CORE_CLK), .d(err_tgl_q), .q(err_sync));

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            // Board starts on its local clock, so nothing is set yet.
            hold_q        <= '0;
            cur_q         <= '0;
            set_q         <= 1'b0;
            busy_q        <= 1'b0;
            req_tgl_q     <= 1'b0;
            rej_q         <= 1'b0;
            grant_q       <= 1'b0;
            crej_q        <= 1'b0;
            errv_q        <= 1'b0;
            errvec_q      <= 8'h00;
            resend_q      <= 1'b0;
            err_ack_tgl_q <= 1'b0;
            ack_seen_q    <= ack_sync;
            err_seen_q    <= err_sync;
        end else begin
            rej_q   <= take_cmd && !cmd_good;
            grant_q <= CONN_VALID && conn_ok;
            crej_q  <= CONN_VALID && !conn_ok;
            errv_q  <= err_evt;
            ack_seen_q <= ack_sync;
            err_seen_q <= err_sync;
            if (take_cmd && cmd_good) begin
                hold_q    <= CMD;
                busy_q    <= 1'b1;
                req_tgl_q <= ~req_tgl_q;
            end
            if (ack_evt) begin
                busy_q <= 1'b0;
                set_q  <= 1'b1;
                cur_q  <= hold_q;
            end
            if (err_evt) begin
                errvec_q      <= err_clean;
                err_ack_tgl_q <= ~err_ack_tgl_q;
            end
            // A new failure wins over the clear from a fresh command.
            if (lost) resend_q <= 1'b1;
            else if (ack_evt) resend_q <= 1'b0;
        end
    end

    // ---------------- link domain ----------------
    logic       link_rst_n;
    logic       req_sync, err_ack_sync, req_seen_q, eack_seen_q;
    logic       wait_q, pend_q;
    logic [7:0] pend_data_q, tx_data_q;
    logic [2:0] idx_q;
    tx_state_e  st_q;

    // The core reset crosses like any other foreign input, so a short
    // glitch on it cannot reset only half of the link logic.
    tdm_clk_sync u_rst_sync (.clk(LINK_CLK), .d(RST_N), .q(link_rst_n));

    tdm_clk_sync u_req_sync (.clk(LINK_CLK), .d(req_tgl_q), .q(req_sync));
    tdm_clk_sync u_eack_sync (.clk(LINK_CLK), .d(err_ack_tgl_q),
                              .q(err_ack_sync));

    wire       req_evt  = req_sync != req_seen_q;
    wire       eack_evt = err_ack_sync != eack_seen_q;
    wire       tx_fire  = st_q == TX_SEND && LINK_TX_READY;
    // The held command is stable while busy, so it may be read across.
    wire [7:0] cmd_byte = (idx_q == 3'h0) ? {4'h0, hold_q.mode} :
                          (idx_q == 3'h1) ? {4'h0, hold_q.submode} :
                          (idx_q == 3'h2) ? {4'h0, hold_q.arg_a} :
                          (idx_q == 3'h3) ? hold_q.arg_bb :
                                            {4'h0, hold_q.arg_c};
    wire       can_post = !wait_q || eack_evt;

    assign LINK_TX_VALID = st_q == TX_SEND;
    assign LINK_TX_DATA  = tx_data_q;

    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n) begin
            st_q        <= TX_IDLE;
            idx_q       <= 3'h0;
            tx_data_q   <= 8'h00;
            ack_tgl_q   <= 1'b0;
            err_tgl_q   <= 1'b0;
            wait_q      <= 1'b0;
            pend_q      <= 1'b0;
            pend_data_q <= 8'h00;
            err_hold_q  <= 8'h00;
            req_seen_q  <= req_sync;
            eack_seen_q <= err_ack_sync;
        end else begin
            req_seen_q  <= req_sync;
            eack_seen_q <= err_ack_sync;
            case (st_q)
                TX_IDLE: begin
                    if (req_evt) begin
                        st_q      <= TX_SEND;
                        idx_q     <= 3'h0;
                        tx_data_q <= {4'h0, hold_q.mode};
                    end
                end
                TX_SEND: begin
                    if (tx_fire) begin
                        if (idx_q == `CMD_LAST) begin
                            st_q      <= TX_IDLE;
                            ack_tgl_q <= ~ack_tgl_q;
                        end else begin
                            idx_q     <= idx_q + 3'h1;
                        end
                    end
                end
                default: st_q <= TX_IDLE;
            endcase
            if (st_q == TX_SEND) tx_data_q <= cmd_byte;
            if (tx_fire && idx_q != `CMD_LAST) begin
                tx_data_q <= (idx_q == 3'h0) ? {4'h0, hold_q.submode} :
                             (idx_q == 3'h1) ? {4'h0, hold_q.arg_a} :
                             (idx_q == 3'h2) ? hold_q.arg_bb :
                                               {4'h0, hold_q.arg_c};
            end
            // Reports arriving while one is in flight keep only the latest.
            if (eack_evt) wait_q <= 1'b0;
            if (LINK_RX_VALID && can_post) begin
                err_hold_q <= LINK_RX_DATA;
                err_tgl_q  <= ~err_tgl_q;
                wait_q     <= 1'b1;
                pend_q     <= 1'b0;
            end else if (LINK_RX_VALID) begin
                pend_q      <= 1'b1;
                pend_data_q <= LINK_RX_DATA;
            end else if (pend_q && can_post) begin
                err_hold_q <= pend_data_q;
                err_tgl_q  <= ~err_tgl_q;
                wait_q     <= 1'b1;
                pend_q     <= 1'b0;
            end
        end
    end
endmodule : tdm_clk_host
`default_nettype wire

// ==== hw/tdm_clk_defs.svh ====
// Purpose: Shared constants for the backplane clock-mode host controller.
// Assumes: Included by its bare name from the design file.
// Notes:   Field codes follow the set-clock command and the error vector.
`ifndef TDM_CLK_DEFS_SVH
`define TDM_CLK_DEFS_SVH

`define MODE_NONE        4'h0
`define MODE_SLAVE       4'h1
`define MODE_PRI_A       4'h2
`define MODE_PRI_B       4'h3
`define MODE_SEC_A       4'h4
`define MODE_SEC_B       4'h5
`define SUB_SLV_A        4'h0
`define SUB_SLV_B        4'h1
`define SUB_SLV_A_FB     4'h6
`define SUB_SLV_B_FB     4'h7
`define SUB_NETREF_ONE   4'h1
`define SUB_NETREF_TWO   4'h2
`define SUB_MST_MAX      4'h5
`define SUB_SEC_MAX      4'h3
`define ARG_A_MAX        4'h2
`define NETREF_8K        8'h00
`define STREAM_MAX       8'h1F
`define SLOT_MAX         8'h7F
`define ERR_BUS_A        0
`define ERR_BUS_B        1
`define ERR_LEGACY_ONE   2
`define ERR_LEGACY_TWO   3
`define ERR_NETREF       4
`define ERR_FRAME        5
`define ERR_KEEP_MASK    8'h33
`define CMD_BYTES        3'h5
`define CMD_LAST         3'h4

`endif

// ==== hw/tdm_clk_pkg.sv ====
// Purpose: Types shared by the clock-mode host controller.
// Assumes: tdm_clk_defs.svh holds the numeric constants.
// Notes:   Fields of the set-clock command travel as one struct.
package tdm_clk_pkg;
    typedef struct packed {
        logic [3:0] mode;
        logic [3:0] submode;
        logic [3:0] arg_a;
        logic [7:0] arg_bb;
        logic [3:0] arg_c;
    } clk_cmd_s;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_e;
endpackage : tdm_clk_pkg

// ==== sim/tdm_clk_host_sva.sv ====
// Purpose: Port checker for the clock-mode host controller.
// Assumes: Bound to tdm_clk_host; link checks run on LINK_CLK.
// Notes:   Pulses are judged at the edge after their cause.
`timescale 1ns/1ps
`default_nettype none
module tdm_clk_host_sva
    import tdm_clk_pkg::*;
(
    // Clocks and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        LINK_CLK,
    // Core side
    input wire logic        CMD_VALID,
    input wire logic        CMD_READY,
    input wire clk_cmd_s    CMD,
    input wire logic        CMD_REJECT,
    input wire logic        CONN_VALID,
    input wire logic [15:0] CONN_SLOT,
    input wire logic        CONN_REJECT,
    input wire logic        CLOCK_SET,
    input wire clk_cmd_s    CUR_CMD,
    input wire logic [7:0]  ERR_VECTOR,
    input wire logic        ERR_VALID,
    input wire logic        RESEND_NEEDED,
    // Link side
    input wire logic        LINK_TX_VALID,
    input wire logic [7:0]  LINK_TX_DATA,
    input wire logic        LINK_TX_READY
);
    chk_mode_range: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) CMD_VALID && CMD_READY && CMD.mode > 4'h5
        |=> CMD_REJECT) else $error("bad mode not refused");
    chk_reject_pulse: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) CMD_REJECT |=> !CMD_REJECT)
        else $error("reject longer than one cycle");
    chk_conn_unset: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) CONN_VALID && !CLOCK_SET |=> CONN_REJECT)
        else $error("connection before clock mode");
    chk_conn_range: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) CONN_VALID && (CONN_SLOT[15:8] > 8'h1F
        || CONN_SLOT[7:0] > 8'h7F) |=> CONN_REJECT)
        else $error("slot out of range granted");
    chk_set_keep: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) CLOCK_SET |=> CLOCK_SET)
        else $error("clock set dropped");
    chk_err_legacy: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) ERR_VECTOR[3:2] == 2'b00)
        else $error("legacy error bits set");
    chk_err_hold: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) !ERR_VALID |-> $stable(ERR_VECTOR))
        else $error("error vector moved without report");
    chk_fallback_flag: assert property (@(posedge CORE_CLK)
        disable iff (!RST_N) ERR_VALID && CUR_CMD.mode == 4'h1
        && CUR_CMD.submode == 4'h6 && ERR_VECTOR[0] |-> ##[0:1]
        RESEND_NEEDED) else $error("fallback not flagged");
    chk_tx_hold: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N) LINK_TX_VALID && !LINK_TX_READY |=>
        LINK_TX_VALID && $stable(LINK_TX_DATA))
        else $error("link byte changed while stalled");
    chk_tx_first: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N) $rose(LINK_TX_VALID) |-> LINK_TX_DATA <= 8'h05)
        else $error("first byte is not a mode");
    cover property (@(posedge CORE_CLK) $rose(CLOCK_SET));
    cover property (@(posedge CORE_CLK) ERR_VALID && RESEND_NEEDED);
    cover property (@(posedge LINK_CLK) LINK_TX_VALID && !LINK_TX_READY);
endmodule : tdm_clk_host_sva
bind tdm_clk_host tdm_clk_host_sva tdm_clk_host_sva_i (.CORE_CLK, .RST_N,
    .LINK_CLK, .CMD_VALID, .CMD_READY, .CMD, .CMD_REJECT, .CONN_VALID,
    .CONN_SLOT, .CONN_REJECT, .CLOCK_SET, .CUR_CMD, .ERR_VECTOR, .ERR_VALID,
    .RESEND_NEEDED, .LINK_TX_VALID, .LINK_TX_DATA, .LINK_TX_READY);
`default_nettype wire

// ==== sim/tdm_board_model.sv ====
// Purpose: Board at the far end of the byte link.
// Assumes: Reports are started by the bench through report().
// Notes:   A slow board accepts a byte only every other link cycle.
`timescale 1ns/1ps
`default_nettype none
module tdm_board_model (
    input  wire logic       link_clk,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data
);
    logic [7:0] got[$];
    logic       tick = 1'b0;
    // Quiet after power-up: nothing is reported until asked.
    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'hA5;
    end
    always @(posedge link_clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tick <= ~tick;
        tx_ready <= !slow || tick;
    end
    task automatic report(input logic [7:0] v);
        @(posedge link_clk);
        rx_valid <= 1'b1;
        rx_data <= v;
        @(posedge link_clk);
        rx_valid <= 1'b0;
        rx_data <= ~v;
    endtask : report
endmodule : tdm_board_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the clock-mode host controller.
// Assumes: Core-side inputs change on the falling core edge; the board model drives link inputs on the rising link edge.
// Notes:   The board model stalls the link during valid commands.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tdm_clk_pkg::*;
;
    logic core_clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, slow = 1'b0;
    logic cmd_valid = 1'b0, conn_valid = 1'b0;
    logic [15:0] conn_slot = 16'h0000;
    clk_cmd_s cmd = 24'h000000, cur_cmd;
    logic cmd_ready, cmd_reject, conn_grant, conn_reject, clock_set;
    logic err_valid, resend, tx_valid, tx_ready, rx_valid;
    logic [7:0] err_vector, tx_data, rx_data;
    int err_count = 0, comparisons = 0;
    clk_cmd_s bad[7] = '{24'h600000, 24'h120000, 24'h103000, 24'h201000,
        24'h260000, 24'h440000, 24'h310010};
    clk_cmd_s ok[10] = '{24'h000000, 24'h101000, 24'h112050, 24'h170000,
        24'h200000, 24'h330120, 24'h250345, 24'h430030, 24'h510000,
        24'h160000};
    always #20 core_clk = ~core_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    tdm_clk_host tdm_clk_host_i (.CORE_CLK(core_clk), .RST_N(rst_n),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
        .CMD_REJECT(cmd_reject), .CONN_VALID(conn_valid),
        .CONN_SLOT(conn_slot), .CONN_GRANT(conn_grant),
        .CONN_REJECT(conn_reject), .CLOCK_SET(clock_set),
        .CUR_CMD(cur_cmd), .ERR_VECTOR(err_vector), .ERR_VALID(err_valid),
        .RESEND_NEEDED(resend), .LINK_CLK(link_clk),
        .LINK_TX_VALID(tx_valid), .LINK_TX_DATA(tx_data),
        .LINK_TX_READY(tx_ready), .LINK_RX_VALID(rx_valid),
        .LINK_RX_DATA(rx_data));
    tdm_board_model mdl (.link_clk(link_clk), .slow(slow),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data));
    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic summarize();
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic send(input clk_cmd_s c, input logic b);
        logic rej;
        @(negedge core_clk);
        cmd = c;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        rej = cmd_reject;
        @(negedge core_clk);
        check("reject", rej | cmd_reject, b);
        for (int k = 0; k < 300 && cmd_ready !== 1'b1; k++)
            @(negedge core_clk);
        check("ready", cmd_ready, 1'b1);
        @(negedge core_clk);
    endtask : send
    task automatic good(input clk_cmd_s c);
        mdl.got.delete();
        send(c, 1'b0);
        check("clock_set", clock_set, 1'b1);
        check("cur_cmd", cur_cmd, c);
        check("bytes", mdl.got.size(), 5);
        if (mdl.got.size() == 5) begin
            check("b0", {mdl.got[0], mdl.got[1]},
                {4'h0, c.mode, 4'h0, c.submode});
            check("b2", {mdl.got[2], mdl.got[3], mdl.got[4]},
                {4'h0, c.arg_a, c.arg_bb, 4'h0, c.arg_c});
        end
    endtask : good
    task automatic conn(input logic [15:0] s, input logic g);
        @(negedge core_clk);
        conn_valid = 1'b1;
        conn_slot = s;
        @(negedge core_clk);
        conn_valid = 1'b0;
        check("grant", {conn_grant, conn_reject}, {g, !g});
    endtask : conn
    task automatic err(input logic [7:0] v, e, input logic r);
        mdl.report(v);
        for (int k = 0; k < 60 && err_valid !== 1'b1; k++)
            @(negedge core_clk);
        check("err_vector", {err_valid, err_vector}, {1'b1, e});
        @(negedge core_clk);
        check("resend", resend, r);
    endtask : err
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        check("idle", {cmd_ready, clock_set, tx_valid}, 3'b100);
        conn(16'h0000, 1'b0);
        foreach (bad[i]) send(bad[i], 1'b1);
        conn(16'h0000, 1'b0);
        slow = 1'b1;
        foreach (ok[i]) good(ok[i]);
        conn(16'h1F7F, 1'b1);
        conn(16'h207F, 1'b0);
        conn(16'h1F80, 1'b0);
        err(8'hFF, 8'h33, 1'b1);
        err(8'h10, 8'h10, 1'b1);
        good(ok[8]);
        check("resend_clear", resend, 1'b0);
        err(8'h02, 8'h02, 1'b0);
        err(8'h01, 8'h01, 1'b1);
        summarize();
    end
    // The whole sequence needs a few hundred cycles at most.
    initial begin
        #2000000;
        err_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
